// [hw/adcct_regs.sv]
// computation register set of the converter: previous result, accumulator,
// filter, error, thresholds, trigger select and interrupt status
// assumes CONV start/done pulses come from logic on CLK_SYS
//
// Functional notes
// - prev_source_select=1: previous result takes filter output at conversion start.
// - prev_source_select=0: previous result takes conversion result at conversion start.
// - with select 0, previous result justified like conversion result per result_format.
// - 16-bit accumulator as high/low bytes, top bit is the sign.
// - 16-bit writable setpoint, an operand of the error in some modes.
// - 16-bit error, formula chosen by three-bit error_calc_select.
// - error compared to lower/upper thresholds updates below/above flags.
// - threshold_int_mode decides whether a comparison raises the interrupt.
// - five-bit auto trigger select, reset zero, bits 7-5 read zero.
// - filter output is accumulator shifted right, or low-pass output in LPF.
// - conversion counter counts triggers and saturates at its maximum.
`timescale 1ns/100ps
`default_nettype none

module adcct_regs (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire adcct_pkg::adcct_bus_type BUS,
  input wire adcct_pkg::adcct_conv_type CONV,
  output logic [7:0] RDATA,
  output logic [4:0] TRIG_SEL,
  output logic IRQ
);

  adcct_pkg::adcct_state_type q, d;

  // ==========================================================
  // helpers
  function automatic logic [15:0] fmt_res(input logic [adcct_pkg::RES_W-1:0] r,
                                          input logic frm);
    fmt_res = frm ? {{adcct_pkg::PAD_W{1'b0}}, r} : {r, {adcct_pkg::PAD_W{1'b0}}};
  endfunction

  logic [2:0] md, calc, tmd, crs;
  logic frm, psis;
  logic [15:0] res_ext, acc_base, acc_n, fltr_n, err_n, prev_expect, res_fmt;
  logic [16:0] sum17;
  logic check, below, above, hit;
  logic wr_hit_res, wr_hit_acc;

  assign md = q.con2[adcct_pkg::MD_HI:adcct_pkg::MD_LO];
  assign crs = q.con2[adcct_pkg::CRS_HI:adcct_pkg::CRS_LO];
  assign psis = q.con2[adcct_pkg::PSIS_BIT];
  assign calc = q.con3[adcct_pkg::CALC_HI:adcct_pkg::CALC_LO];
  assign tmd = q.con3[adcct_pkg::TMD_HI:adcct_pkg::TMD_LO];
  assign frm = q.con0[adcct_pkg::FRM_BIT];
  assign res_fmt = fmt_res(q.res, frm);
  assign prev_expect = psis ? q.fltr : res_fmt;

  // ==========================================================
  // computation on conversion done
  always_comb begin
    res_ext = {{adcct_pkg::PAD_W{1'b0}}, CONV.result};
    // average modes restart after each completed check
    acc_base = ((md == adcct_pkg::MD_AVG || md == adcct_pkg::MD_BURST) && q.math)
               ? '0 : q.acc;
    sum17 = {acc_base[15], acc_base} + {1'b0, res_ext};
    if (md == adcct_pkg::MD_LPF) begin
      sum17 = sum17 - {q.acc[15], 16'($signed(q.acc) >>> crs)};
    end
    acc_n = (md == adcct_pkg::MD_BASIC) ? q.acc : sum17[15:0];
    fltr_n = 16'($signed(acc_n) >>> crs);
    case (calc)
      adcct_pkg::CALC_RES_PREV: err_n = res_ext - q.prev;
      adcct_pkg::CALC_RES_SET: err_n = res_ext - q.stpt;
      adcct_pkg::CALC_FLT_SET: err_n = fltr_n - q.stpt;
      adcct_pkg::CALC_FLT_PREV: err_n = fltr_n - q.prev;
      default: err_n = res_ext - q.stpt;
    endcase
    check = (md == adcct_pkg::MD_BASIC) || (md == adcct_pkg::MD_ACCUM) ||
            (q.cnt >= q.rpt);
    below = $signed(err_n) < $signed(q.lth);
    above = $signed(err_n) > $signed(q.uth);
    case (tmd)
      adcct_pkg::TMD_NEVER: hit = 1'b0;
      adcct_pkg::TMD_BELOW: hit = below;
      adcct_pkg::TMD_NOT_BELOW: hit = !below;
      adcct_pkg::TMD_OUTSIDE: hit = below || above;
      adcct_pkg::TMD_INSIDE: hit = !below && !above;
      adcct_pkg::TMD_NOT_ABOVE: hit = !above;
      adcct_pkg::TMD_ABOVE: hit = above;
      default: hit = 1'b1;
    endcase
  end

  assign wr_hit_res = BUS.wr && (BUS.addr == adcct_pkg::A_RESH ||
                                 BUS.addr == adcct_pkg::A_RESL);
  assign wr_hit_acc = BUS.wr && (BUS.addr == adcct_pkg::A_ACCH ||
                                 BUS.addr == adcct_pkg::A_ACCL);

  // ==========================================================
  // next state
  always_comb begin
    logic [1:0] iset;
    logic [1:0] iclr;
    iset = '0;
    iclr = '0;
    d = q;
    d.rdata = '0;

    // conversion start counts a trigger and snapshots the previous value
    if (CONV.start) begin
      d.cnt = (q.cnt == adcct_pkg::CNT_MAX) ? q.cnt : q.cnt + adcct_pkg::CNT_ONE;
      if ((md == adcct_pkg::MD_AVG || md == adcct_pkg::MD_BURST) && q.math) begin
        d.cnt = adcct_pkg::CNT_ONE;
      end
      d.prev = prev_expect;
    end

    if (CONV.done) begin
      d.res = CONV.result;
      d.acc = acc_n;
      d.aov = q.aov || (md != adcct_pkg::MD_BASIC && (sum17[16] != sum17[15]));
      d.fltr = fltr_n;
      d.err = err_n;
      d.math = check;
      iset[adcct_pkg::INT_DONE] = 1'b1;
      if (check) begin
        d.lthr = below;
        d.uthr = above;
        iset[adcct_pkg::INT_THR] = hit;
      end
    end

    // register writes; error, filter and previous result are not written
    if (BUS.wr) begin
      case (BUS.addr)
        adcct_pkg::A_CON0: d.con0 = BUS.wdata;
        adcct_pkg::A_CON1: d.con1 = BUS.wdata;
        adcct_pkg::A_CON2: begin
          d.con2 = BUS.wdata;
          d.con2[adcct_pkg::ACLR_BIT] = 1'b0;
          if (BUS.wdata[adcct_pkg::ACLR_BIT]) begin
            d.acc = '0;
            d.cnt = '0;
            d.aov = 1'b0;
            d.math = 1'b0;
          end
        end
        adcct_pkg::A_CON3: d.con3 = BUS.wdata;
        adcct_pkg::A_ACT: d.act = BUS.wdata & adcct_pkg::LOW5_MASK;
        adcct_pkg::A_ACCH: d.acc[15:8] = BUS.wdata;
        adcct_pkg::A_ACCL: d.acc[7:0] = BUS.wdata;
        adcct_pkg::A_RESH: begin
          if (frm) begin
            d.res[adcct_pkg::RES_W-1:8] = BUS.wdata[1:0];
          end else begin
            d.res[adcct_pkg::RES_W-1:2] = BUS.wdata;
          end
        end
        adcct_pkg::A_RESL: begin
          if (frm) begin
            d.res[7:0] = BUS.wdata;
          end else begin
            d.res[1:0] = BUS.wdata[7:6];
          end
        end
        adcct_pkg::A_CLK: d.clk = BUS.wdata;
        adcct_pkg::A_REF: d.refs = BUS.wdata;
        adcct_pkg::A_CAP: d.cap = BUS.wdata & adcct_pkg::LOW5_MASK;
        adcct_pkg::A_PRE: d.pre = BUS.wdata;
        adcct_pkg::A_ACQ: d.acq = BUS.wdata;
        adcct_pkg::A_PCH: d.pch = BUS.wdata;
        adcct_pkg::A_CNT: d.cnt = BUS.wdata;
        adcct_pkg::A_RPT: d.rpt = BUS.wdata;
        adcct_pkg::A_LTHL: d.lth[7:0] = BUS.wdata;
        adcct_pkg::A_LTHH: d.lth[15:8] = BUS.wdata;
        adcct_pkg::A_UTHL: d.uth[7:0] = BUS.wdata;
        adcct_pkg::A_UTHH: d.uth[15:8] = BUS.wdata;
        adcct_pkg::A_STPTL: d.stpt[7:0] = BUS.wdata;
        adcct_pkg::A_STPTH: d.stpt[15:8] = BUS.wdata;
        adcct_pkg::A_ISTAT: iclr = BUS.wdata[1:0];
        adcct_pkg::A_IMASK: d.imask = BUS.wdata[1:0];
        default: d.imask = d.imask;
      endcase
    end

    // set wins over a write-one clear in the same cycle
    d.istat = (q.istat & ~iclr) | iset;
    d.irq = |(d.istat & d.imask);

    if (BUS.rd) begin
      case (BUS.addr)
        adcct_pkg::A_CON0: d.rdata = q.con0;
        adcct_pkg::A_CON1: d.rdata = q.con1;
        adcct_pkg::A_CON2: d.rdata = q.con2;
        adcct_pkg::A_CON3: d.rdata = q.con3;
        adcct_pkg::A_ACT: d.rdata = q.act;
        adcct_pkg::A_ACCH: d.rdata = q.acc[15:8];
        adcct_pkg::A_ACCL: d.rdata = q.acc[7:0];
        adcct_pkg::A_PREVH: d.rdata = q.prev[15:8];
        adcct_pkg::A_PREVL: d.rdata = q.prev[7:0];
        adcct_pkg::A_RESH: d.rdata = res_fmt[15:8];
        adcct_pkg::A_RESL: d.rdata = res_fmt[7:0];
        adcct_pkg::A_STAT: begin
          d.rdata[adcct_pkg::ST_AOV] = q.aov;
          d.rdata[adcct_pkg::ST_UTHR] = q.uthr;
          d.rdata[adcct_pkg::ST_LTHR] = q.lthr;
          d.rdata[adcct_pkg::ST_MATH] = q.math;
        end
        adcct_pkg::A_CLK: d.rdata = q.clk;
        adcct_pkg::A_REF: d.rdata = q.refs;
        adcct_pkg::A_CAP: d.rdata = q.cap;
        adcct_pkg::A_PRE: d.rdata = q.pre;
        adcct_pkg::A_ACQ: d.rdata = q.acq;
        adcct_pkg::A_PCH: d.rdata = q.pch;
        adcct_pkg::A_CNT: d.rdata = q.cnt;
        adcct_pkg::A_RPT: d.rdata = q.rpt;
        adcct_pkg::A_LTHL: d.rdata = q.lth[7:0];
        adcct_pkg::A_LTHH: d.rdata = q.lth[15:8];
        adcct_pkg::A_UTHL: d.rdata = q.uth[7:0];
        adcct_pkg::A_UTHH: d.rdata = q.uth[15:8];
        adcct_pkg::A_STPTL: d.rdata = q.stpt[7:0];
        adcct_pkg::A_STPTH: d.rdata = q.stpt[15:8];
        adcct_pkg::A_FLTRL: d.rdata = q.fltr[7:0];
        adcct_pkg::A_FLTRH: d.rdata = q.fltr[15:8];
        adcct_pkg::A_ERRL: d.rdata = q.err[7:0];
        adcct_pkg::A_ERRH: d.rdata = q.err[15:8];
        adcct_pkg::A_ISTAT: d.rdata[1:0] = q.istat;
        adcct_pkg::A_IMASK: d.rdata[1:0] = q.imask;
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= adcct_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign TRIG_SEL = q.act[4:0];
  assign IRQ = q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  logic quiet;
  assign quiet = !BUS.wr;

  sequence s_done_checked;
    CONV.done && check && quiet;
  endsequence

  sequence s_thr_event;
    CONV.done && check && hit && q.imask[adcct_pkg::INT_THR] && quiet;
  endsequence

  sequence s_avg_restart;
    CONV.start && (md == adcct_pkg::MD_AVG || md == adcct_pkg::MD_BURST) &&
    q.math && quiet;
  endsequence

  a_prev_from_filter: assert property (
    CONV.start && psis && quiet |=> q.prev == $past(q.fltr))
    else $error("previous result not taken from filter");

  a_prev_from_result: assert property (
    CONV.start && !psis && quiet |=> q.prev == $past(res_fmt))
    else $error("previous result not taken from conversion result");

  a_prev_justify: assert property (
    CONV.start && !psis && frm && quiet |=> q.prev[15:adcct_pkg::RES_W] == '0)
    else $error("previous result not right justified");

  a_setpoint_error: assert property (
    CONV.done && calc == adcct_pkg::CALC_RES_SET && quiet
    |=> q.err == 16'($past(res_ext) - $past(q.stpt)))
    else $error("error differs from result minus setpoint");

  a_filter_shift: assert property (
    CONV.done && md == adcct_pkg::MD_ACCUM && quiet
    |=> q.fltr == 16'($signed(q.acc) >>> $past(crs)))
    else $error("filter output not shifted accumulator");

  a_flags_signed: assert property (
    s_done_checked |=> q.uthr == ($signed(q.err) > $signed(q.uth)) &&
                       q.lthr == ($signed(q.err) < $signed(q.lth)))
    else $error("threshold flags wrong after comparison");

  a_thr_irq: assert property (
    s_thr_event |=> q.istat[adcct_pkg::INT_THR] ##0 IRQ)
    else $error("threshold hit did not raise interrupt");

  a_trig_write: assert property (
    BUS.wr && BUS.addr == adcct_pkg::A_ACT |=> TRIG_SEL == $past(BUS.wdata[4:0])
    && q.act[7:5] == '0)
    else $error("trigger select write wrong");

  a_cnt_saturate: assert property (
    CONV.start && q.cnt == adcct_pkg::CNT_MAX && !q.math && quiet
    |=> q.cnt == adcct_pkg::CNT_MAX)
    else $error("conversion count wrapped");

  a_err_readonly: assert property (
    BUS.wr && BUS.addr == adcct_pkg::A_ERRH && !CONV.done |=> $stable(q.err))
    else $error("error register took a write");

  // ==========================================================
  // capture and hold
  a_res_capture: assert property (
    CONV.done && !wr_hit_res |=> q.res == $past(CONV.result))
    else $error("conversion result not captured");

  a_res_hold: assert property (
    !CONV.done && !wr_hit_res |=> $stable(q.res))
    else $error("conversion result changed without cause");

  a_acc_sum: assert property (
    CONV.done && md == adcct_pkg::MD_ACCUM && quiet
    |=> q.acc == 16'($past(q.acc) + $past(res_ext)))
    else $error("accumulator did not add the result");

  a_acc_hold: assert property (
    !CONV.done && !wr_hit_acc && !(BUS.wr && BUS.addr == adcct_pkg::A_CON2)
    |=> $stable(q.acc))
    else $error("accumulator changed without cause");

  a_acc_clear: assert property (
    BUS.wr && BUS.addr == adcct_pkg::A_CON2 && BUS.wdata[adcct_pkg::ACLR_BIT]
    |=> q.acc == '0 && q.cnt == '0)
    else $error("accumulator clear not applied");

  a_lpf_filter: assert property (
    CONV.done && md == adcct_pkg::MD_LPF && quiet
    |=> q.fltr == 16'($signed(q.acc) >>> $past(crs)))
    else $error("low-pass output not shifted accumulator");

  a_avg_restart: assert property (
    s_avg_restart |=> q.cnt == adcct_pkg::CNT_ONE)
    else $error("average count did not restart");

  a_cnt_count: assert property (
    CONV.start && q.cnt != adcct_pkg::CNT_MAX && !q.math && quiet
    |=> q.cnt == 8'($past(q.cnt) + adcct_pkg::CNT_ONE))
    else $error("conversion count did not advance");

  a_done_sticky: assert property (
    CONV.done |=> q.istat[adcct_pkg::INT_DONE])
    else $error("done status not set");

  a_thr_quiet: assert property (
    CONV.done && check && !hit && quiet && !q.istat[adcct_pkg::INT_THR]
    |=> !q.istat[adcct_pkg::INT_THR])
    else $error("threshold status set without a hit");

  a_flags_hold: assert property (
    !CONV.done |=> $stable(q.lthr) && $stable(q.uthr))
    else $error("threshold flags changed without a check");

  a_err_hold: assert property (
    !CONV.done |=> $stable(q.err))
    else $error("error changed without a conversion");

  a_fltr_hold: assert property (
    !CONV.done |=> $stable(q.fltr))
    else $error("filter output changed without a conversion");

  a_prev_hold: assert property (
    !CONV.start |=> $stable(q.prev))
    else $error("previous result changed without a start");

endmodule

`default_nettype wire

// [hw/adcct_pkg.sv]
// constants, field layout and carrier types of the converter computation registers
// assumes a single 125 MHz system clock and an 8-bit register port
package adcct_pkg;

  typedef logic [4:0] adcct_addr_type;

  // register indices
  localparam adcct_addr_type A_CON0 = 5'h00;
  localparam adcct_addr_type A_CON1 = 5'h01;
  localparam adcct_addr_type A_CON2 = 5'h02;
  localparam adcct_addr_type A_CON3 = 5'h03;
  localparam adcct_addr_type A_ACT = 5'h04;
  localparam adcct_addr_type A_ACCH = 5'h05;
  localparam adcct_addr_type A_ACCL = 5'h06;
  localparam adcct_addr_type A_PREVH = 5'h07;
  localparam adcct_addr_type A_PREVL = 5'h08;
  localparam adcct_addr_type A_RESH = 5'h09;
  localparam adcct_addr_type A_RESL = 5'h0A;
  localparam adcct_addr_type A_STAT = 5'h0B;
  localparam adcct_addr_type A_CLK = 5'h0C;
  localparam adcct_addr_type A_REF = 5'h0D;
  localparam adcct_addr_type A_CAP = 5'h0E;
  localparam adcct_addr_type A_PRE = 5'h0F;
  localparam adcct_addr_type A_ACQ = 5'h10;
  localparam adcct_addr_type A_PCH = 5'h11;
  localparam adcct_addr_type A_CNT = 5'h12;
  localparam adcct_addr_type A_RPT = 5'h13;
  localparam adcct_addr_type A_LTHL = 5'h14;
  localparam adcct_addr_type A_LTHH = 5'h15;
  localparam adcct_addr_type A_UTHL = 5'h16;
  localparam adcct_addr_type A_UTHH = 5'h17;
  localparam adcct_addr_type A_STPTL = 5'h18;
  localparam adcct_addr_type A_STPTH = 5'h19;
  localparam adcct_addr_type A_FLTRL = 5'h1A;
  localparam adcct_addr_type A_FLTRH = 5'h1B;
  localparam adcct_addr_type A_ERRL = 5'h1C;
  localparam adcct_addr_type A_ERRH = 5'h1D;
  localparam adcct_addr_type A_ISTAT = 5'h1E;
  localparam adcct_addr_type A_IMASK = 5'h1F;

  // field positions
  localparam int FRM_BIT = 2;
  localparam int PSIS_BIT = 7;
  localparam int CRS_HI = 6;
  localparam int CRS_LO = 4;
  localparam int ACLR_BIT = 3;
  localparam int MD_HI = 2;
  localparam int MD_LO = 0;
  localparam int CALC_HI = 6;
  localparam int CALC_LO = 4;
  localparam int TMD_HI = 2;
  localparam int TMD_LO = 0;
  localparam int ST_AOV = 7;
  localparam int ST_UTHR = 6;
  localparam int ST_LTHR = 5;
  localparam int ST_MATH = 4;
  localparam int INT_DONE = 0;
  localparam int INT_THR = 1;
  localparam int RES_W = 10;
  localparam int PAD_W = 6;

  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] LOW5_MASK = 8'h1F;

  // averaging modes
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACCUM = 3'h1;
  localparam logic [2:0] MD_AVG = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF = 3'h4;

  // error formulas
  localparam logic [2:0] CALC_RES_PREV = 3'h0;
  localparam logic [2:0] CALC_RES_SET = 3'h1;
  localparam logic [2:0] CALC_FLT_SET = 3'h2;
  localparam logic [2:0] CALC_FLT_PREV = 3'h3;

  // threshold interrupt modes
  localparam logic [2:0] TMD_NEVER = 3'h0;
  localparam logic [2:0] TMD_BELOW = 3'h1;
  localparam logic [2:0] TMD_NOT_BELOW = 3'h2;
  localparam logic [2:0] TMD_OUTSIDE = 3'h3;
  localparam logic [2:0] TMD_INSIDE = 3'h4;
  localparam logic [2:0] TMD_NOT_ABOVE = 3'h5;
  localparam logic [2:0] TMD_ABOVE = 3'h6;

  typedef struct packed {
    adcct_addr_type addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcct_bus_type;

  typedef struct packed {
    logic start;
    logic done;
    logic [RES_W-1:0] result;
  } adcct_conv_type;

  typedef struct packed {
    logic [7:0] con0, con1, con2, con3, act, clk, refs, cap, pre, acq, pch, cnt, rpt;
    logic [RES_W-1:0] res;
    logic [15:0] acc, prev, stpt, lth, uth, err, fltr;
    logic aov, uthr, lthr, math;
    logic [1:0] istat, imask;
    logic irq;
    logic [7:0] rdata;
  } adcct_state_type;

  localparam adcct_state_type STATE_RST = '0;

endpackage

// [test/adcct_tb.sv]
// self-checking bench for the converter computation register set
// assumes adcct_pkg and adcct_regs are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  adcct_pkg::adcct_bus_type bus = '0;
  adcct_pkg::adcct_conv_type conv = '0;
  logic [7:0] rdata;
  logic [4:0] trig_sel;
  logic irq;
  logic [15:0] expq[$];
  logic [15:0] note;
  logic rd_seen = 1'b0;
  int failures = 0;
  int checked = 0;
  integer seed = 32'h91f6cf07;
  localparam adcct_pkg::adcct_addr_type RO_LIST [6] = '{adcct_pkg::A_PREVH,
    adcct_pkg::A_PREVL, adcct_pkg::A_FLTRH, adcct_pkg::A_FLTRL, adcct_pkg::A_ERRH,
    adcct_pkg::A_ERRL};
  localparam adcct_pkg::adcct_addr_type RW_LIST [9] = '{adcct_pkg::A_ACCH,
    adcct_pkg::A_ACCL, adcct_pkg::A_STPTH, adcct_pkg::A_STPTL, adcct_pkg::A_LTHH,
    adcct_pkg::A_LTHL, adcct_pkg::A_UTHH, adcct_pkg::A_UTHL, adcct_pkg::A_RPT};

  always #4 clk_sys = ~clk_sys;

  adcct_regs dut (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .BUS(bus),
    .CONV(conv),
    .RDATA(rdata),
    .TRIG_SEL(trig_sel),
    .IRQ(irq)
  );

  // ==========================================
  // comparison and verdict
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    checked++;
    if ((g & m) !== e) begin
      failures++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_lvl(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  // ==========================================
  // read data watcher
  always @(posedge clk_sys) rd_seen <= bus.rd;

  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      chk_rd(note[7:0], rdata, note[15:8]);
    end else begin
      chk_rd(8'h00, rdata, 8'hFF);
    end
  end

  // ==========================================
  // drivers
  task automatic wr(input adcct_pkg::adcct_addr_type a, input logic [7:0] d);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input adcct_pkg::adcct_addr_type a, input logic [7:0] e,
                    input logic [7:0] m);
    expq.push_back({m, e});
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
  endtask

  task automatic pulse(input logic s, input logic d, input logic [9:0] r);
    @(posedge clk_sys);
    conv.start <= s;
    conv.done <= d;
    conv.result <= r;
    @(posedge clk_sys);
    conv.start <= 1'b0;
    conv.done <= 1'b0;
    conv.result <= ~r;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic hit_of(input logic [2:0] md, input logic b, input logic a);
    case (md)
      3'h0: hit_of = 1'b0;
      3'h1: hit_of = b;
      3'h2: hit_of = !b;
      3'h3: hit_of = b | a;
      3'h4: hit_of = !b && !a;
      3'h5: hit_of = !a;
      3'h6: hit_of = a;
      default: hit_of = 1'b1;
    endcase
  endfunction

  // ==========================================
  // main sequence
  initial begin : main
    logic [7:0] v;
    logic [9:0] r;
    logic [15:0] er;
    logic b;
    logic a;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(adcct_pkg::A_ACT, 8'h00, 8'hFF);
    chk_lvl(8'h00, {3'h0, trig_sel});
    for (int i = 0; i < 6; i++) begin
      wr(RO_LIST[i], 8'hA5);
      rd(RO_LIST[i], 8'h00, 8'hFF);
    end
    v = 8'($random(seed));
    wr(adcct_pkg::A_ACT, v | 8'hE0);
    rd(adcct_pkg::A_ACT, v & 8'h1F, 8'hFF);
    settle();
    chk_lvl(v & 8'h1F, {3'h0, trig_sel});
    end_test("reset_and_access");
    for (int i = 0; i < 9; i++) begin
      v = 8'($random(seed));
      wr(RW_LIST[i], v);
      rd(RW_LIST[i], v, 8'hFF);
    end
    end_test("read_write");
    wr(adcct_pkg::A_CNT, 8'hFD);
    pulse(1'b1, 1'b0, 10'h000);
    rd(adcct_pkg::A_CNT, 8'hFE, 8'hFF);
    pulse(1'b1, 1'b0, 10'h000);
    pulse(1'b1, 1'b0, 10'h000);
    rd(adcct_pkg::A_CNT, 8'hFF, 8'hFF);
    end_test("counter");
    wr(adcct_pkg::A_CON0, 8'h04);
    wr(adcct_pkg::A_CON2, 8'h00);
    pulse(1'b0, 1'b1, 10'h2C5);
    pulse(1'b1, 1'b0, 10'h000);
    rd(adcct_pkg::A_PREVH, 8'h02, 8'hFF);
    rd(adcct_pkg::A_PREVL, 8'hC5, 8'hFF);
    wr(adcct_pkg::A_CON0, 8'h00);
    pulse(1'b1, 1'b0, 10'h000);
    rd(adcct_pkg::A_PREVH, 8'hB1, 8'hFF);
    rd(adcct_pkg::A_PREVL, 8'h40, 8'hC0);
    wr(adcct_pkg::A_CON0, 8'h04);
    end_test("previous_result");
    wr(adcct_pkg::A_CON2, 8'h99);
    pulse(1'b0, 1'b1, 10'h123);
    pulse(1'b0, 1'b1, 10'h0F1);
    rd(adcct_pkg::A_ACCH, 8'h02, 8'hFF);
    rd(adcct_pkg::A_ACCL, 8'h14, 8'hFF);
    rd(adcct_pkg::A_FLTRH, 8'h01, 8'hFF);
    rd(adcct_pkg::A_FLTRL, 8'h0A, 8'hFF);
    pulse(1'b1, 1'b0, 10'h000);
    rd(adcct_pkg::A_PREVH, 8'h01, 8'hFF);
    rd(adcct_pkg::A_PREVL, 8'h0A, 8'hFF);
    end_test("filter");
    wr(adcct_pkg::A_CON2, 8'h00);
    wr(adcct_pkg::A_STPTH, 8'h02);
    wr(adcct_pkg::A_STPTL, 8'h00);
    wr(adcct_pkg::A_LTHH, 8'h00);
    wr(adcct_pkg::A_LTHL, 8'h10);
    wr(adcct_pkg::A_UTHH, 8'h00);
    wr(adcct_pkg::A_UTHL, 8'h20);
    wr(adcct_pkg::A_IMASK, 8'h00);
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? 10'h100 : ((k == 1) ? 10'h218 : 10'h300);
      b = (k == 0);
      a = (k == 2);
      er = {6'h00, r} - 16'h0200;
      for (int m = 0; m < 8; m++) begin
        wr(adcct_pkg::A_CON3, 8'h10 | 8'(m));
        wr(adcct_pkg::A_ISTAT, 8'h03);
        pulse(1'b0, 1'b1, r);
        rd(adcct_pkg::A_ISTAT, {6'h00, hit_of(m[2:0], b, a), 1'b1}, 8'h03);
      end
      rd(adcct_pkg::A_STAT, {1'b0, a, b, 5'h00}, 8'h60);
      rd(adcct_pkg::A_ERRH, er[15:8], 8'hFF);
      rd(adcct_pkg::A_ERRL, er[7:0], 8'hFF);
    end
    end_test("thresholds");
    settle();
    chk_lvl(8'h00, {7'h00, irq});
    wr(adcct_pkg::A_IMASK, 8'h02);
    settle();
    chk_lvl(8'h01, {7'h00, irq});
    wr(adcct_pkg::A_IMASK, 8'h01);
    settle();
    chk_lvl(8'h01, {7'h00, irq});
    wr(adcct_pkg::A_ISTAT, 8'h01);
    settle();
    chk_lvl(8'h00, {7'h00, irq});
    rd(adcct_pkg::A_ISTAT, 8'h02, 8'h03);
    end_test("interrupt");
    for (int n = 2; n < 4; n++) begin
      wr(adcct_pkg::A_CON2, 8'h28 | 8'(n));
      wr(adcct_pkg::A_RPT, 8'h02);
      wr(adcct_pkg::A_CON3, 8'h20);
      for (int k = 0; k < 3; k++) begin
        pulse(1'b1, 1'b0, 10'h000);
        pulse(1'b0, 1'b1, (k == 1) ? 10'h200 : 10'h100);
        if (k == 1) begin
          rd(adcct_pkg::A_STAT, 8'h30, 8'hF0);
          rd(adcct_pkg::A_ERRH, 8'hFE, 8'hFF);
          rd(adcct_pkg::A_ERRL, 8'hC0, 8'hFF);
        end
      end
      rd(adcct_pkg::A_CNT, 8'h01, 8'hFF);
      rd(adcct_pkg::A_ACCH, 8'h01, 8'hFF);
      rd(adcct_pkg::A_ACCL, 8'h00, 8'hFF);
      rd(adcct_pkg::A_STAT, 8'h00, 8'h10);
    end
    end_test("averaging");
    wr(adcct_pkg::A_CON2, 8'h1C);
    pulse(1'b1, 1'b0, 10'h000);
    wr(adcct_pkg::A_CON3, 8'h00);
    pulse(1'b0, 1'b1, 10'h180);
    rd(adcct_pkg::A_ERRH, 8'h00, 8'hFF);
    rd(adcct_pkg::A_ERRL, 8'h80, 8'hFF);
    wr(adcct_pkg::A_CON3, 8'h30);
    pulse(1'b0, 1'b1, 10'h100);
    rd(adcct_pkg::A_ACCH, 8'h01, 8'hFF);
    rd(adcct_pkg::A_ACCL, 8'hC0, 8'hFF);
    rd(adcct_pkg::A_FLTRH, 8'h00, 8'hFF);
    rd(adcct_pkg::A_FLTRL, 8'hE0, 8'hFF);
    rd(adcct_pkg::A_ERRH, 8'hFF, 8'hFF);
    rd(adcct_pkg::A_ERRL, 8'hE0, 8'hFF);
    end_test("lowpass");
    for (int i = 0; i < 20 && expq.size() > 0; i++) begin
      @(posedge clk_sys);
    end
    if (expq.size() > 0) begin
      failures++;
    end
    stop_test();
  end

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys);
    failures++;
    stop_test();
  end
endmodule

`default_nettype wire
